// ==== verification/test_reset_event_status_logic.sv ====
`timescale 1ns/1ps
module test_reset_event_status_logic import rgm_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, fess, fbre, mk;
  logic pready, pslverr, e, sys_reset, ext_reset_pad, safe_mode, irq;
  logic [7:0] des_event = 8'h00, func_event = 8'h00, safe_cause = 8'h00;
  logic [1:0] reset_phase;
  int bad_count = 0, n_compared = 0, i, j, k, len;
  logic des;

  // free running system clock
  always #4 pclk = ~pclk;

  rgm_reset_gen #(.NDES(8), .NFUNC(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .des_event(des_event), .func_event(func_event),
    .safe_cause(safe_cause), .reset_phase(reset_phase), .sys_reset(sys_reset),
    .ext_reset_pad(ext_reset_pad), .safe_mode(safe_mode), .irq(irq));

  // one place for every comparison, so counts stay honest
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // apb transfer; the request is held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        bad_count++;
        give_verdict();
      end
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  // bounded wait on sys_reset, sampled mid-cycle where it is settled
  task wait_sys(input logic lvl, output int n);
    n = 0;
    while (sys_reset !== lvl)
    begin
      @(negedge pclk);
      n++;
      if (n > 1000)
      begin
        bad_count++;
        give_verdict();
      end
    end
  endtask

  // expected sequence length: short runs only the third phase
  function automatic logic [31:0] exp_len(input logic short_seq);
    if (short_seq)
      return 32'(PH3_CYC);
    return 32'(PH1_CYC) + 32'(PH2_CYC) + 32'(PH3_CYC);
  endfunction

  // one reset event and the sequence it launches
  task run_event(input logic d, input int s, input logic sh, input logic pad);
    @(posedge pclk);
    if (d)
      des_event[s] <= 1'b1;
    else
      func_event[s] <= 1'b1;
    wait_sys(1'b1, len);
    check(reset_phase, (sh && !d) ? PH_RESET_THIRD : PH_RESET_FIRST);
    check(ext_reset_pad, pad | d);
    @(posedge pclk);
    des_event <= 8'h00;
    func_event <= 8'h00;
    wait_sys(1'b0, len);
    check(len, exp_len(sh && !d));
  endtask

  initial
  begin
    void'($urandom(32'hd01dc2f1));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(FESS_OFS, 32'h0);
    rd(FBRE_OFS, 32'h0);
    rd(IRQ_MK_OFS, 32'h0);
    apb(1'b0, 8'h40, 32'hffff_ffff);
    check({q[30:0], e}, 32'h1);
    $display("test reset values done");
    for (k = 0; k < 6; k++)
    begin
      i = $urandom_range(7, 0);
      fess = (k == 0) ? 32'hff : (k == 1) ? 32'h0 : $urandom;
      // k == 0 is the corner with pad enable and short select together
      fbre = (k == 0) ? 32'hff : ($urandom & ~fess);
      mk = $urandom_range(7, 0);
      des = (k == 5);
      apb(1'b1, FESS_OFS, fess);
      rd(FESS_OFS, fess & 32'hff);
      apb(1'b1, FBRE_OFS, fbre);
      rd(FBRE_OFS, fbre & 32'hff);
      apb(1'b1, IRQ_MK_OFS, mk);
      run_event(des, i, fess[i], fbre[i]);
      rd(des ? DES_OFS : FES_OFS, 32'h1 << i);
      @(negedge pclk);
      check(irq, |(mk[2:0] & (des ? 3'h1 : 3'h2)));
      apb(1'b1, des ? DES_OFS : FES_OFS, 32'hff);
      // status shows the clear still in flight right after the write
      rd(STAT_OFS, 32'h1 << STAT_BUSY_BIT);
      rd(des ? DES_OFS : FES_OFS, 32'h0);
      apb(1'b1, IRQ_ST_OFS, 32'h7);
      @(negedge pclk);
      check(irq, 1'b0);
    end
    $display("test event sequences done");
    // a sequence start drops a clear in flight; later clears still work
    run_event(1'b0, 1, fess[1], fbre[1]);
    @(posedge pclk);
    func_event[0] <= 1'b1;
    apb(1'b1, FES_OFS, 32'h2);
    @(posedge pclk);
    func_event <= 8'h00;
    wait_sys(1'b1, len);
    wait_sys(1'b0, len);
    rd(FES_OFS, 32'h3);
    apb(1'b1, FES_OFS, 32'h3);
    rd(STAT_OFS, 32'h1 << STAT_BUSY_BIT);
    rd(FES_OFS, 32'h0);
    apb(1'b1, IRQ_ST_OFS, 32'h7);
    $display("test aborted clear done");
    // fallback exit is refused while a cause stays high
    j = $urandom_range(7, 0);
    @(posedge pclk);
    safe_cause[j] <= 1'b1;
    repeat (5) @(negedge pclk);
    check(safe_mode, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h1);
    repeat (2) @(negedge pclk);
    check(safe_mode, 1'b1);
    rd(IRQ_ST_OFS, 32'h4);
    @(posedge pclk);
    safe_cause <= 8'h00;
    repeat (5) @(negedge pclk);
    apb(1'b1, CTRL_OFS, 32'h1);
    repeat (2) @(negedge pclk);
    check(safe_mode, 1'b0);
    $display("test fallback exit done");
    give_verdict();
  end
endmodule

// ==== verilog/rgm_clr_sync.sv ====
`timescale 1ns/1ps
module rgm_clr_sync import rgm_pkg::*; #(
  parameter int W = 16
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic flush, // drop any clear in flight
  input wire logic [W-1:0] req, // one-cycle clear request
  output logic [W-1:0] apply, // clear applies to flags now
  output logic busy // a clear is in flight
);
  typedef struct packed {
    logic [W-1:0] stage;
    logic [W-1:0] apply;
  } rgm_sync_type;

  rgm_sync_type s_r, s_nxt;

  // two-stage clear pipe; a flush throws the pending clear away but
  // leaves the pipe empty, so the next request runs normally
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.stage = flush ? '0 : req;
    s_nxt.apply = flush ? '0 : s_r.stage;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign apply = s_r.apply;
  assign busy = |{s_r.stage, s_r.apply};
endmodule

// ==== verilog/rgm_pkg.sv ====
package rgm_pkg;
  // register byte offsets
  localparam logic [7:0] DES_OFS = 8'h00;
  localparam logic [7:0] FES_OFS = 8'h04;
  localparam logic [7:0] FESS_OFS = 8'h08;
  localparam logic [7:0] FBRE_OFS = 8'h0c;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_ST_OFS = 8'h18;
  localparam logic [7:0] IRQ_MK_OFS = 8'h1c;
  // field positions
  localparam int CTRL_EXIT_BIT = 0;
  localparam int STAT_SAFE_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam int IRQ_DES_BIT = 0;
  localparam int IRQ_FES_BIT = 1;
  localparam int IRQ_REFUSE_BIT = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [31:0] FESS_RST = 32'h0000_0000;
  localparam logic [31:0] FBRE_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MK_RST = 3'h0;
  // timing: clock and phase lengths
  localparam int CLK_NS = 8;
  localparam int PH1_NS = 1000;
  localparam int PH2_NS = 1000;
  localparam int PH3_NS = 500;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] PH1_CYC = CNT_W'((PH1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PH2_CYC = CNT_W'((PH2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PH3_CYC = CNT_W'((PH3_NS + CLK_NS - 1) / CLK_NS);
  // reset sequence phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RESET_FIRST = 2'b01,
    PH_RESET_SECOND = 2'b10,
    PH_RESET_THIRD = 2'b11
  } rgm_phase_type;
endpackage

// ==== verilog/rgm_reset_gen.sv ====
// How it works
// [RQ1] flag clear finishes through two-stage sync
// [RQ2] reset aborts pending clear, next clears unaffected
// [RQ3] software reads status back before software reset
// [RQ4] short select starts at third phase
// [RQ5] per-source pad enable and short select
// [RQ6] software avoids pad enable with short select
// [RQ7] fallback exit refused while cause active
// [RQ8] software removes cause before clearing flag
// [RQ9] hardware sets flags, write one clears
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rgm_reset_gen import rgm_pkg::*; #(
  parameter int NDES = 8,
  parameter int NFUNC = 8
) (
  input wire logic pclk, // system clock, 125 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [NDES-1:0] des_event, // destructive reset sources
  input wire logic [NFUNC-1:0] func_event, // functional reset sources
  input wire logic [NFUNC-1:0] safe_cause, // fallback mode causes, levels
  output logic [1:0] reset_phase, // current sequence phase
  output logic sys_reset, // high while a sequence runs
  output logic ext_reset_pad, // drive external reset pad
  output logic safe_mode, // fallback mode active
  output logic irq // level interrupt
);
  localparam int CW = NDES + NFUNC;

  typedef struct packed {
    logic [NDES-1:0] des_m;
    logic [NDES-1:0] des_s;
    logic [NDES-1:0] des_p;
    logic [NFUNC-1:0] fun_m;
    logic [NFUNC-1:0] fun_s;
    logic [NFUNC-1:0] fun_p;
    logic [NFUNC-1:0] saf_m;
    logic [NFUNC-1:0] saf_s;
    logic [NDES-1:0] des_flag;
    logic [NFUNC-1:0] fes_flag;
    logic [NFUNC-1:0] fess;
    logic [NFUNC-1:0] fbre;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mk;
    rgm_phase_type phase;
    logic [CNT_W-1:0] cnt;
    logic pad;
    logic safe;
    logic [31:0] prdata;
    logic pslverr;
  } rgm_state_type;

  rgm_state_type s_r, s_nxt;
  logic [NDES-1:0] des_rise;
  logic [NFUNC-1:0] fun_rise;
  logic acc_wr;
  logic start;
  logic short_seq;
  logic pad_req;
  logic exit_req;
  logic refused;
  logic [CW-1:0] clr_req;
  logic [CW-1:0] clr_apply;
  logic clr_busy;
  logic [IRQ_W-1:0] irq_w1c;

  // edge detect on the second sync stage only
  assign des_rise = s_r.des_s & ~s_r.des_p;
  assign fun_rise = s_r.fun_s & ~s_r.fun_p;
  assign acc_wr = psel && penable && pwrite;
  assign start = (s_r.phase == PH_IDLE) && ((|des_rise) || (|fun_rise));
  // destructive events always take the long path
  assign short_seq = !(|des_rise) && ((fun_rise & ~s_r.fess) == '0); // RQ4
  // the pad follows the enables of the functional sources that fired, also with short; any destructive event always drives it
  assign pad_req = (|des_rise) || (|(fun_rise & s_r.fbre)); // RQ5
  assign exit_req = acc_wr && (paddr == CTRL_OFS) && pwdata[CTRL_EXIT_BIT];
  assign refused = exit_req && (|s_r.saf_s); // RQ7

  // software flag clears pass through the sync pipe; a starting sequence
  // aborts a clear in flight, which then leaves the flag set
  rgm_clr_sync #(
    .W(CW)
  ) u_clr_sync (
    .pclk(pclk),
    .presetn(presetn),
    .flush(start), // RQ2
    .req(clr_req), // RQ1
    .apply(clr_apply),
    .busy(clr_busy)
  );

  // write-one-to-clear requests from the bus
  always_comb
  begin
    clr_req = '0;
    irq_w1c = '0;
    if (acc_wr && paddr == DES_OFS)
    begin
      clr_req[NDES-1:0] = pwdata[NDES-1:0]; // RQ9
    end
    if (acc_wr && paddr == FES_OFS)
    begin
      clr_req[CW-1:NDES] = pwdata[NFUNC-1:0]; // RQ9
    end
    if (acc_wr && paddr == IRQ_ST_OFS)
    begin
      irq_w1c = pwdata[IRQ_W-1:0];
    end
  end

  // next state of the whole block
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.des_m = des_event;
    s_nxt.des_s = s_r.des_m;
    s_nxt.des_p = s_r.des_s;
    s_nxt.fun_m = func_event;
    s_nxt.fun_s = s_r.fun_m;
    s_nxt.fun_p = s_r.fun_s;
    s_nxt.saf_m = safe_cause;
    s_nxt.saf_s = s_r.saf_m;
    // read data is latched in the setup phase so it sits in a flop
    if (psel && !penable)
    begin
      s_nxt.pslverr = 1'b0;
      unique case (paddr)
        DES_OFS: s_nxt.prdata = 32'(s_r.des_flag);
        FES_OFS: s_nxt.prdata = 32'(s_r.fes_flag);
        FESS_OFS: s_nxt.prdata = 32'(s_r.fess);
        FBRE_OFS: s_nxt.prdata = 32'(s_r.fbre);
        CTRL_OFS: s_nxt.prdata = 32'h0000_0000;
        STAT_OFS: s_nxt.prdata = 32'({clr_busy, s_r.safe, s_r.pad, s_r.phase});
        IRQ_ST_OFS: s_nxt.prdata = 32'(s_r.irq_st);
        IRQ_MK_OFS: s_nxt.prdata = 32'(s_r.irq_mk);
        default:
        begin
          s_nxt.prdata = 32'h0000_0000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // configuration writes
    if (acc_wr && paddr == FESS_OFS)
    begin
      s_nxt.fess = pwdata[NFUNC-1:0]; // RQ5
    end
    if (acc_wr && paddr == FBRE_OFS)
    begin
      s_nxt.fbre = pwdata[NFUNC-1:0]; // RQ5
    end
    if (acc_wr && paddr == IRQ_MK_OFS)
    begin
      s_nxt.irq_mk = pwdata[IRQ_W-1:0];
    end
    // flags: a new event wins over a clear landing the same cycle
    s_nxt.des_flag = (s_r.des_flag & ~clr_apply[NDES-1:0]) | des_rise; // RQ9
    s_nxt.fes_flag = (s_r.fes_flag & ~clr_apply[CW-1:NDES]) | fun_rise; // RQ9
    s_nxt.irq_st = (s_r.irq_st & ~irq_w1c) | {refused, |fun_rise, |des_rise};
    // fallback mode: the cause level, not the flag, holds the mode
    if (|s_r.saf_s)
    begin
      s_nxt.safe = 1'b1; // RQ7
    end
    else if (exit_req)
    begin
      s_nxt.safe = 1'b0;
    end
    // reset sequencer; events during a sequence are flagged only
    unique case (s_r.phase)
      PH_IDLE:
      begin
        if (start)
        begin
          s_nxt.phase = short_seq ? PH_RESET_THIRD : PH_RESET_FIRST; // RQ4
          s_nxt.cnt = short_seq ? PH3_CYC - 1'b1 : PH1_CYC - 1'b1;
          s_nxt.pad = pad_req; // RQ5
        end
      end
      PH_RESET_FIRST:
      begin
        s_nxt.cnt = s_r.cnt - 1'b1;
        if (s_r.cnt == '0)
        begin
          s_nxt.phase = PH_RESET_SECOND;
          s_nxt.cnt = PH2_CYC - 1'b1;
        end
      end
      PH_RESET_SECOND:
      begin
        s_nxt.cnt = s_r.cnt - 1'b1;
        if (s_r.cnt == '0)
        begin
          s_nxt.phase = PH_RESET_THIRD;
          s_nxt.cnt = PH3_CYC - 1'b1;
        end
      end
      PH_RESET_THIRD:
      begin
        s_nxt.cnt = s_r.cnt - 1'b1;
        if (s_r.cnt == '0)
        begin
          s_nxt.phase = PH_IDLE;
          s_nxt.cnt = '0;
          s_nxt.pad = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.fess <= FESS_RST[NFUNC-1:0];
      s_r.fbre <= FBRE_RST[NFUNC-1:0];
      s_r.irq_mk <= IRQ_MK_RST;
      s_r.phase <= PH_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs; zero wait states keep the bus simple
  assign prdata = s_r.prdata;
  assign pready = 1'b1;
  assign pslverr = s_r.pslverr;
  assign reset_phase = s_r.phase;
  assign sys_reset = (s_r.phase != PH_IDLE);
  assign ext_reset_pad = s_r.pad;
  assign safe_mode = s_r.safe;
  assign irq = |(s_r.irq_st & s_r.irq_mk);

  // a clear request reaches the flags two cycles later unless flushed
  a_clear_two_cyc: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    (clr_req[NDES] && !start) ##1 !start |-> ##1 clr_apply[NDES])
    else $error("clear did not apply after two cycles");
  a_clear_lands: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (clr_apply[NDES] && !fun_rise[0]) |=> !s_r.fes_flag[0])
    else $error("applied clear left flag set");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    fun_rise[0] |=> s_r.fes_flag[0])
    else $error("event lost against clear");
  a_flush_empty: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    start |=> !clr_busy)
    else $error("clear survived a sequence start");
  a_short_third: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (start && short_seq) |=> (s_r.phase == PH_RESET_THIRD) && (s_r.cnt == PH3_CYC - 1'b1))
    else $error("short sequence not at third phase");
  a_long_first: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    (start && !short_seq) |=> (s_r.phase == PH_RESET_FIRST) && (s_r.cnt == PH1_CYC - 1'b1))
    else $error("long sequence not at first phase");
  a_pad_follow: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    start |=> (ext_reset_pad == $past(pad_req)) && sys_reset)
    else $error("pad does not follow source enables");
  a_safe_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (|s_r.saf_s) |=> safe_mode && !(exit_req && !safe_mode))
    else $error("fallback mode left with cause active");
endmodule
